// File: hdl/span_fill_pattern_write.sv
// framebuffer write stage: block fills, pattern spans, upload packing, vblank stall
//
// Design decisions made here: register access over Wishbone and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
module span_fill_pattern_write (
  // clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic wb_err_o,
  // span input from rasteriser
  input wire logic span_valid,
  input wire fbw_pkg::span_req_t span_req,
  input wire logic [31:0] span_color,
  output logic span_ready,
  // frame blank pin
  input wire logic vblank_pin,
  // framebuffer write output
  output logic fb_valid_ff,
  output fbw_pkg::fb_write_t fb_write_ff,
  input wire logic fb_ready,
  // host output fifo (upload)
  output logic up_valid_ff,
  output logic [31:0] up_data_ff,
  // swap outputs
  output logic [31:0] video_reg_ff,
  output logic [31:0] row_base_ff
);
  // register state
  logic store_allow_flag_ff;
  logic host_upload_pack_flag_ff;
  fbw_pkg::depth_t depth_ff;
  logic [63:0] fill_color_ff;
  logic tile_mem_on_ff;
  logic [4:0] xmask_ff;
  logic [2:0] yshift_ff;
  logic [4:0] ymask_ff;
  logic [23:0] window_base_address_ff;
  logic [23:0] pixel_address_offset_ff;
  logic [23:0] copy_source_offset_ff;
  logic stall_pending_ff;
  fbw_pkg::swap_t swap_action_select_ff;
  logic [31:0] video_stage_ff;
  logic [31:0] row_stage_ff;
  logic vb_s1_ff;
  logic vb_s2_ff;
  logic vb_prev_ff;
  logic vb_rise;
  // span pipeline
  logic busy_ff;
  fbw_pkg::span_req_t req_ff;
  logic [31:0] hold_color_ff;
  logic [4:0] word_ff;
  logic [4:0] last_word;
  logic mem_we;
  logic [4:0] mem_waddr;
  logic [4:0] tile_addr;
  logic [31:0] tile_rdata;
  logic rd_wait_ff;
  logic [1:0] pack_cnt_ff;
  logic [31:0] pack_ff;
  logic wr_en;
  logic bus_req;
  logic bus_wr;
  logic [31:0] nxt_rdata;
  logic nxt_err;

  // row plus column pattern address, cut to five bits
  function automatic logic [4:0] tile_word(input logic on, input logic [4:0] y, input logic [2:0] sh,
                                           input logic [4:0] ym, input logic [4:0] xm, input logic [4:0] w);
    logic [4:0] yo;
    logic [4:0] xo;
    yo = 5'((y << sh)) & ym;
    xo = w & xm;
    if (on) begin
      tile_word = 5'(yo + xo);
    end else begin
      tile_word = w;
    end
  endfunction : tile_word

  // words per span minus one, by depth
  function automatic logic [4:0] span_words(input fbw_pkg::depth_t d);
    unique case (d)
      fbw_pkg::DEPTH_8: span_words = 5'h07;
      fbw_pkg::DEPTH_16: span_words = 5'h0F;
      default: span_words = 5'h1F;
    endcase
  endfunction : span_words

  assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
  assign bus_wr = bus_req && wb_we_i;
  assign last_word = span_words(depth_ff);
  assign tile_addr = tile_word(tile_mem_on_ff, req_ff.y, yshift_ff, ymask_ff, xmask_ff, word_ff);
  assign mem_we = bus_wr && (wb_adr_i[7] == 1'b1);
  assign mem_waddr = wb_adr_i[6:2];
  // a pending stall holds writes until the next blank
  assign wr_en = store_allow_flag_ff && !stall_pending_ff;

  tile_mem #(.WORDS(32), .AW(5)) u_tile_mem (
    .mclk(mclk),
    .we(mem_we),
    .waddr(mem_waddr),
    .wdata(wb_dat_i),
    .raddr(tile_addr),
    .rdata_ff(tile_rdata)
  );

  // frame blank pin synchroniser and edge
  always_ff @(posedge mclk) begin
    vb_s1_ff <= vblank_pin;
    vb_s2_ff <= vb_s1_ff;
    vb_prev_ff <= resetn ? vb_s2_ff : 1'b0;
  end
  assign vb_rise = vb_s2_ff && !vb_prev_ff;

  // wishbone ack, one cycle after request
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      wb_ack_o <= 1'b0;
      wb_err_o <= 1'b0;
      wb_dat_o <= fbw_pkg::RST_ZERO;
    end else begin
      wb_ack_o <= bus_req && !nxt_err;
      wb_err_o <= bus_req && nxt_err;
      wb_dat_o <= bus_req ? nxt_rdata : fbw_pkg::RST_ZERO;
    end
  end

  // read mux and unmapped decode
  always_comb begin
    nxt_rdata = fbw_pkg::RST_ZERO;
    nxt_err = 1'b0;
    if (wb_adr_i[7]) begin
      nxt_rdata = fbw_pkg::RST_ZERO; // pattern memory is write only
    end else begin
      unique case (wb_adr_i)
        fbw_pkg::ADR_STORE_CFG: nxt_rdata = {28'h0000000, depth_ff, host_upload_pack_flag_ff, store_allow_flag_ff};
        fbw_pkg::ADR_FILL_SINGLE: nxt_rdata = fill_color_ff[31:0];
        fbw_pkg::ADR_FILL_LOW: nxt_rdata = fill_color_ff[31:0];
        fbw_pkg::ADR_FILL_HIGH: nxt_rdata = fill_color_ff[63:32];
        fbw_pkg::ADR_TILE_CFG: nxt_rdata = {18'h00000, ymask_ff, yshift_ff, xmask_ff, tile_mem_on_ff};
        fbw_pkg::ADR_WIN_BASE: nxt_rdata = {8'h00, window_base_address_ff};
        fbw_pkg::ADR_PIX_OFS: nxt_rdata = {{8{pixel_address_offset_ff[23]}}, pixel_address_offset_ff};
        fbw_pkg::ADR_SRC_OFS: nxt_rdata = {{8{copy_source_offset_ff[23]}}, copy_source_offset_ff};
        fbw_pkg::ADR_STALL_CMD: nxt_rdata = {30'h00000000, swap_action_select_ff};
        fbw_pkg::ADR_STATUS: nxt_rdata = {30'h00000000, busy_ff, stall_pending_ff};
        fbw_pkg::ADR_VIDEO_REG: nxt_rdata = video_reg_ff;
        fbw_pkg::ADR_ROW_BASE: nxt_rdata = row_base_ff;
        default: nxt_err = 1'b1;
      endcase
    end
  end

  // mode and colour registers; sel ignored, whole words
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      store_allow_flag_ff <= 1'b0;
      host_upload_pack_flag_ff <= 1'b0;
      depth_ff <= fbw_pkg::DEPTH_32;
      fill_color_ff <= {fbw_pkg::RST_ZERO, fbw_pkg::RST_ZERO};
      tile_mem_on_ff <= 1'b0;
      xmask_ff <= 5'h00;
      yshift_ff <= 3'h0;
      ymask_ff <= 5'h00;
      window_base_address_ff <= 24'h000000;
      pixel_address_offset_ff <= 24'h000000;
      copy_source_offset_ff <= 24'h000000;
      video_stage_ff <= fbw_pkg::RST_ZERO;
      row_stage_ff <= fbw_pkg::RST_ZERO;
    end else if (bus_wr && !wb_adr_i[7]) begin
      unique case (wb_adr_i)
        fbw_pkg::ADR_STORE_CFG: begin
          store_allow_flag_ff <= wb_dat_i[fbw_pkg::STORE_ALLOW_BIT];
          host_upload_pack_flag_ff <= wb_dat_i[fbw_pkg::UPLOAD_BIT];
          depth_ff <= fbw_pkg::depth_t'(wb_dat_i[fbw_pkg::DEPTH_LSB +: 2]);
        end
        fbw_pkg::ADR_FILL_SINGLE: fill_color_ff <= {wb_dat_i, wb_dat_i};
        fbw_pkg::ADR_FILL_LOW: fill_color_ff[31:0] <= wb_dat_i;
        fbw_pkg::ADR_FILL_HIGH: fill_color_ff[63:32] <= wb_dat_i;
        fbw_pkg::ADR_TILE_CFG: begin
          tile_mem_on_ff <= wb_dat_i[fbw_pkg::TILE_ON_BIT];
          xmask_ff <= wb_dat_i[fbw_pkg::XMASK_LSB +: 5];
          yshift_ff <= wb_dat_i[fbw_pkg::YSHIFT_LSB +: 3];
          ymask_ff <= wb_dat_i[fbw_pkg::YMASK_LSB +: 5];
        end
        fbw_pkg::ADR_WIN_BASE: window_base_address_ff <= wb_dat_i[23:0];
        fbw_pkg::ADR_PIX_OFS: pixel_address_offset_ff <= wb_dat_i[23:0];
        fbw_pkg::ADR_SRC_OFS: copy_source_offset_ff <= wb_dat_i[23:0];
        fbw_pkg::ADR_VIDEO_REG: video_stage_ff <= wb_dat_i;
        fbw_pkg::ADR_ROW_BASE: row_stage_ff <= wb_dat_i;
        default: ;
      endcase
    end
  end

  // stall command and buffer swap
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      stall_pending_ff <= 1'b0;
      swap_action_select_ff <= fbw_pkg::SWAP_VB_VIDEO;
      video_reg_ff <= fbw_pkg::RST_ZERO;
      row_base_ff <= fbw_pkg::RST_ZERO;
    end else if (bus_wr && wb_adr_i == fbw_pkg::ADR_STALL_CMD) begin
      swap_action_select_ff <= fbw_pkg::swap_t'(wb_dat_i[fbw_pkg::SWAP_LSB +: 2]);
      if (wb_dat_i[fbw_pkg::SWAP_LSB +: 2] == 2'b01) begin
        video_reg_ff <= video_stage_ff;
      end else begin
        stall_pending_ff <= 1'b1;
      end
    end else if (stall_pending_ff && vb_rise) begin
      stall_pending_ff <= 1'b0;
      if (swap_action_select_ff == fbw_pkg::SWAP_VB_ROW) begin
        row_base_ff <= row_stage_ff;
      end else begin
        video_reg_ff <= video_stage_ff;
      end
    end
  end

  // span accept and word walk; never locks up
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      busy_ff <= 1'b0;
      req_ff <= '0;
      hold_color_ff <= fbw_pkg::RST_ZERO;
      word_ff <= 5'h00;
      rd_wait_ff <= 1'b0;
    end else if (!busy_ff) begin
      rd_wait_ff <= 1'b0;
      if (span_valid) begin
        busy_ff <= 1'b1;
        req_ff <= span_req;
        hold_color_ff <= span_color;
        word_ff <= 5'h00;
      end
    end else if (!req_ff.variable_color_span_select) begin
      // a block fill is one write for all 32 pixels
      if (!wr_en || (!fb_valid_ff || fb_ready)) begin
        busy_ff <= !wr_en ? stall_pending_ff && store_allow_flag_ff : 1'b0;
      end
    end else if (!rd_wait_ff) begin
      rd_wait_ff <= 1'b1; // one cycle for the registered memory read
    end else if (!(wr_en && fb_valid_ff && !fb_ready) && !(stall_pending_ff && store_allow_flag_ff)) begin
      rd_wait_ff <= 1'b0;
      word_ff <= 5'(word_ff + 5'h01);
      busy_ff <= word_ff != last_word;
    end
  end
  assign span_ready = !busy_ff;

  // framebuffer write generation
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      fb_valid_ff <= 1'b0;
      fb_write_ff <= '0;
    end else if (fb_valid_ff && !fb_ready) begin
      fb_valid_ff <= 1'b1;
    end else if (busy_ff && wr_en && !req_ff.variable_color_span_select) begin
      fb_valid_ff <= 1'b1;
      fb_write_ff.block <= 1'b1;
      fb_write_ff.mask <= req_ff.mask;
      fb_write_ff.data <= fill_color_ff;
      fb_write_ff.addr <= 24'(window_base_address_ff + req_ff.base_x + pixel_address_offset_ff);
      fb_write_ff.src_addr <= 24'(window_base_address_ff + req_ff.base_x + pixel_address_offset_ff
                                  + copy_source_offset_ff);
    end else if (busy_ff && wr_en && rd_wait_ff) begin
      fb_valid_ff <= 1'b1;
      fb_write_ff.block <= 1'b0;
      fb_write_ff.mask <= req_ff.mask;
      fb_write_ff.data <= {32'h00000000, req_ff.wait_host_data_flag ? hold_color_ff : tile_rdata};
      fb_write_ff.addr <= 24'(window_base_address_ff + req_ff.base_x + {19'h00000, word_ff}
                              + pixel_address_offset_ff);
      fb_write_ff.src_addr <= 24'(window_base_address_ff + req_ff.base_x + {19'h00000, word_ff}
                                  + pixel_address_offset_ff + copy_source_offset_ff);
    end else begin
      fb_valid_ff <= 1'b0;
    end
  end

  // upload packing: narrow pixels gathered into whole words
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      up_valid_ff <= 1'b0;
      up_data_ff <= fbw_pkg::RST_ZERO;
      pack_cnt_ff <= 2'b00;
      pack_ff <= fbw_pkg::RST_ZERO;
    end else begin
      up_valid_ff <= 1'b0;
      if (busy_ff && rd_wait_ff && req_ff.variable_color_span_select && host_upload_pack_flag_ff
          && !store_allow_flag_ff) begin
        unique case (depth_ff)
          fbw_pkg::DEPTH_8: begin
            pack_ff <= {tile_rdata[7:0], pack_ff[31:8]};
            pack_cnt_ff <= 2'(pack_cnt_ff + 2'b01);
            up_valid_ff <= pack_cnt_ff == 2'b11;
            up_data_ff <= {tile_rdata[7:0], pack_ff[31:8]};
          end
          fbw_pkg::DEPTH_16: begin
            pack_ff <= {tile_rdata[15:0], pack_ff[31:16]};
            pack_cnt_ff <= {1'b0, ~pack_cnt_ff[0]};
            up_valid_ff <= pack_cnt_ff[0];
            up_data_ff <= {tile_rdata[15:0], pack_ff[31:16]};
          end
          default: begin
            up_valid_ff <= 1'b1;
            up_data_ff <= tile_rdata;
          end
        endcase
      end
    end
  end
endmodule : span_fill_pattern_write
`default_nettype wire

// File: hdl/tile_mem.sv
// 32 word pattern memory with registered read data
`timescale 1ns/1ns
`default_nettype none
module tile_mem #(
  parameter int WORDS = 32,
  parameter int AW = 5
) (
  // clock
  input wire logic mclk,
  // write port
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [31:0] wdata,
  // read port
  input wire logic [AW-1:0] raddr,
  output logic [31:0] rdata_ff
);
  logic [31:0] mem [WORDS];

  // storage write, no reset so it maps to ram
  always_ff @(posedge mclk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  // registered read
  always_ff @(posedge mclk) begin
    rdata_ff <= mem[raddr];
  end
endmodule : tile_mem
`default_nettype wire

// File: pkg/fbw_pkg.sv
// package: register map, fields and types of the span write stage
// Function
// - framebuffer writes only while the store allow flag is set
// - span select zero: block fill the 32 pixel span with fill colour
// - block fill always covers 32 pixels whatever depth or memory
// - single fill colour write fills both 32-bit halves
// - fill colour also loadable as separate low and high 32 bit halves
// - upload with writes off packs four 8-bit or two 16-bit pixels per word
// - pattern memory: 32 words of 32 bits, span packed format
// - row part is (low five y bits << y shift) & y mask
// - column part is word offset within span masked by x mask
// - pattern word address is row part plus column part
// - shift and mask fields apply only while pattern enable is set
// - pattern mode value one makes every span read word zero
// - pattern data aligned to span start with no reference point
// - stall command holds framebuffer writes until vblank; rest proceeds
// - swap action: vblank then video reg, immediate, or vblank then row base
// - window base 24-bit unsigned, pixel and source offsets 24-bit signed
// - pixel offset on every address, source offset also on source reads
package fbw_pkg;
  // register byte addresses
  localparam logic [7:0] ADR_STORE_CFG = 8'h00;
  localparam logic [7:0] ADR_FILL_SINGLE = 8'h04;
  localparam logic [7:0] ADR_FILL_LOW = 8'h08;
  localparam logic [7:0] ADR_FILL_HIGH = 8'h0C;
  localparam logic [7:0] ADR_TILE_CFG = 8'h10;
  localparam logic [7:0] ADR_WIN_BASE = 8'h14;
  localparam logic [7:0] ADR_PIX_OFS = 8'h18;
  localparam logic [7:0] ADR_SRC_OFS = 8'h1C;
  localparam logic [7:0] ADR_STALL_CMD = 8'h20;
  localparam logic [7:0] ADR_STATUS = 8'h24;
  localparam logic [7:0] ADR_VIDEO_REG = 8'h28;
  localparam logic [7:0] ADR_ROW_BASE = 8'h2C;
  localparam logic [7:0] ADR_TILE_BASE = 8'h80;
  // store config fields
  localparam int STORE_ALLOW_BIT = 0;
  localparam int UPLOAD_BIT = 1;
  localparam int DEPTH_LSB = 2;
  // tile config fields
  localparam int TILE_ON_BIT = 0;
  localparam int XMASK_LSB = 1;
  localparam int YSHIFT_LSB = 6;
  localparam int YMASK_LSB = 9;
  // stall command field
  localparam int SWAP_LSB = 0;
  // reset value, span pixel count and address width
  localparam logic [31:0] RST_ZERO = 32'h0000_0000;
  localparam int SPAN_PIXELS = 32;
  localparam int ADDR_W = 24;
  // pixel depth codes
  typedef enum logic [1:0] {
    DEPTH_8 = 2'b00,
    DEPTH_16 = 2'b01,
    DEPTH_32 = 2'b10
  } depth_t;
  // swap actions
  typedef enum logic [1:0] {
    SWAP_VB_VIDEO = 2'b00,
    SWAP_NOW_VIDEO = 2'b01,
    SWAP_VB_ROW = 2'b10
  } swap_t;
  // one span request from the rasteriser
  typedef struct packed {
    logic variable_color_span_select;
    logic wait_host_data_flag;
    logic is_copy;
    logic [4:0] y;
    logic [23:0] base_x;
    logic [31:0] mask;
  } span_req_t;
  // one framebuffer write
  typedef struct packed {
    logic block;
    logic [23:0] addr;
    logic [23:0] src_addr;
    logic [31:0] mask;
    logic [63:0] data;
  } fb_write_t;
endpackage : fbw_pkg

// File: tb/fb_mem_model.sv
// framebuffer model: accepts writes, can stall
`timescale 1ns/1ns
`default_nettype none
module fb_mem_model (
  // clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // stall mode
  input wire logic slow,
  // write handshake
  output logic fb_ready
);
  logic [1:0] cnt_ff;
  // slow mode: ready one cycle in four, writes must hold
  always_ff @(posedge mclk) begin
    cnt_ff <= resetn ? cnt_ff + 2'h1 : 2'h0;
    fb_ready <= !slow || (cnt_ff == 2'h3);
  end
endmodule : fb_mem_model
`default_nettype wire

// File: tb/span_fill_pattern_write_asserts.sv
// port assertions for the span write stage
`timescale 1ns/1ns
`default_nettype none
module span_fill_pattern_write_chk (
  // clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // register bus
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic wb_ack_o,
  input wire logic wb_err_o,
  // span and framebuffer
  input wire logic span_valid,
  input wire fbw_pkg::span_req_t span_req,
  input wire logic span_ready,
  input wire logic vblank_pin,
  input wire logic fb_valid_ff,
  input wire fbw_pkg::fb_write_t fb_write_ff,
  input wire logic fb_ready
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);
  logic req, wr, take, allow_ff, stall_ff;
  logic [63:0] fill_ff;
  logic [31:0] mask_ff;
  // request, done write, span take
  assign req = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
  assign wr = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;
  assign take = span_valid && span_ready;
  // allow and stall shadows; stall clear is coarse on purpose
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      allow_ff <= 1'b0;
      stall_ff <= 1'b0;
    end else begin
      if (wr && wb_adr_i == fbw_pkg::ADR_STORE_CFG) allow_ff <= wb_dat_i[fbw_pkg::STORE_ALLOW_BIT];
      if (wr && wb_adr_i == fbw_pkg::ADR_STALL_CMD) stall_ff <= wb_dat_i[1:0] != fbw_pkg::SWAP_NOW_VIDEO;
      else if (vblank_pin) stall_ff <= 1'b0;
    end
  end
  // fill colour and span mask shadows
  always_ff @(posedge mclk) begin
    if (wr && wb_adr_i == fbw_pkg::ADR_FILL_SINGLE) fill_ff <= {wb_dat_i, wb_dat_i};
    if (wr && wb_adr_i == fbw_pkg::ADR_FILL_LOW) fill_ff[31:0] <= wb_dat_i;
    if (wr && wb_adr_i == fbw_pkg::ADR_FILL_HIGH) fill_ff[63:32] <= wb_dat_i;
    if (take) mask_ff <= span_req.mask;
  end
  chk_store_gate: assert property (fb_valid_ff |-> allow_ff)
    else $error("write while disabled");
  chk_ack_next: assert property (req |=> (wb_ack_o ^ wb_err_o))
    else $error("no answer in one cycle");
  chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack too long");
  chk_err_unmapped: assert property (req && wb_adr_i inside {[8'h30:8'h7F]} |=> wb_err_o && !wb_ack_o)
    else $error("unmapped not refused");
  chk_write_hold: assert property (fb_valid_ff && !fb_ready |=> fb_valid_ff && $stable(fb_write_ff))
    else $error("pending write changed");
  chk_fill_value: assert property (fb_valid_ff && fb_write_ff.block |-> fb_write_ff.data == fill_ff)
    else $error("fill colour wrong");
  chk_fill_mask: assert property (fb_valid_ff && fb_write_ff.block |-> fb_write_ff.mask == mask_ff)
    else $error("fill mask wrong");
  chk_block_launch: assert property (take && !span_req.variable_color_span_select && allow_ff && !stall_ff
    |=> ##1 fb_valid_ff && fb_write_ff.block)
    else $error("fill not launched");
  chk_span_busy: assert property (take |=> !span_ready)
    else $error("ready after take");
  cover property (take && span_req.variable_color_span_select);
  cover property (fb_valid_ff && !fb_ready);
  cover property (wb_err_o);
endmodule : span_fill_pattern_write_chk
bind span_fill_pattern_write span_fill_pattern_write_chk span_fill_pattern_write_chk_inst (
  .mclk(mclk), .resetn(resetn), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o),
  .span_valid(span_valid), .span_req(span_req), .span_ready(span_ready), .vblank_pin(vblank_pin),
  .fb_valid_ff(fb_valid_ff), .fb_write_ff(fb_write_ff), .fb_ready(fb_ready));
`default_nettype wire

// File: tb/testbench.sv
// self-checking bench for the span write stage
`timescale 1ns/1ns
`default_nettype none
module testbench;
  logic mclk, resetn, cyc, stb, we, span_valid, vblank_pin, slow, errq;
  logic wb_ack_o, wb_err_o, span_ready, fb_valid_ff, fb_ready, up_valid_ff;
  logic [7:0] adr;
  logic [31:0] dat, span_color, rdq, rnd, r, ev, er, wb_dat_o, up_data_ff, video_reg_ff, row_base_ff;
  logic [63:0] fill;
  logic [23:0] win, pix, src;
  logic [31:0] pat [32];
  logic [13:0] tcfg [5] = '{14'h0001, 14'h3E87, 14'h3E8F, 14'h308F, 14'h3E8E};
  logic [1:0] tdep [5] = '{2'h2, 2'h1, 2'h2, 2'h2, 2'h0};
  logic [4:0] ty [5] = '{5'h13, 5'h05, 5'h07, 5'h06, 5'h03};
  fbw_pkg::span_req_t span_req;
  fbw_pkg::fb_write_t fb_write_ff;
  fbw_pkg::fb_write_t fbq [$];
  logic [31:0] upq [$];
  int n_mismatch = 0;
  int comparisons = 0;
  span_fill_pattern_write span_fill_pattern_write_inst (
    .mclk(mclk), .resetn(resetn), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o),
    .span_valid(span_valid), .span_req(span_req), .span_color(span_color), .span_ready(span_ready),
    .vblank_pin(vblank_pin), .fb_valid_ff(fb_valid_ff), .fb_write_ff(fb_write_ff), .fb_ready(fb_ready),
    .up_valid_ff(up_valid_ff), .up_data_ff(up_data_ff), .video_reg_ff(video_reg_ff),
    .row_base_ff(row_base_ff));
  fb_mem_model fb_mem_model_inst (.mclk(mclk), .resetn(resetn), .slow(slow), .fb_ready(fb_ready));
  // 20 MHz clock
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  function automatic logic [31:0] nxt();
    rnd = {rnd[30:0], rnd[31] ^ rnd[21] ^ rnd[1] ^ rnd[0]};
    return rnd;
  endfunction : nxt
  function automatic fbw_pkg::fb_write_t mk(input logic b, input logic [23:0] x, input logic [63:0] d,
    input logic [31:0] m);
    fbw_pkg::fb_write_t w;
    w.block = b;
    w.addr = win + x + pix;
    w.src_addr = w.addr + src;
    w.mask = m;
    w.data = d;
    return w;
  endfunction : mk
  // pattern word for word k at row y
  function automatic int paddr(input logic [13:0] t, input int y, input int k);
    if (!t[0]) return k;
    return ((((y << t[8:6]) & 31) & t[13:9]) + (k & t[5:1])) & 31;
  endfunction : paddr
  task automatic stop_test;
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : stop_test
  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // one framebuffer write against its note
  task automatic chk_fb(input fbw_pkg::fb_write_t e, input fbw_pkg::fb_write_t g);
    chk("fb block", 64'(e.block), 64'(g.block));
    chk("fb addr", 64'(e.addr), 64'(g.addr));
    chk("fb src addr", 64'(e.src_addr), 64'(g.src_addr));
    chk("fb data", e.data, g.data);
  endtask : chk_fb
  // one classic wishbone cycle, held until ack or err
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    @(posedge mclk);
    while (!(wb_ack_o || wb_err_o)) @(posedge mclk);
    rdq = wb_dat_o;
    errq = wb_err_o;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb
  task automatic send(input logic vs, input logic hd, input logic cp, input logic [4:0] y, input logic [23:0] bx,
    input logic [31:0] m, input logic [31:0] c);
    @(posedge mclk);
    span_valid <= 1'b1;
    span_req <= '{vs, hd, cp, y, bx, m};
    span_color <= c;
    @(posedge mclk);
    while (!span_ready) @(posedge mclk);
    span_valid <= 1'b0;
  endtask : send
  task automatic wait_idle;
    int n = 0;
    @(posedge mclk);
    while ((!span_ready || fbq.size() + upq.size() != 0) && n < 400) begin
      @(posedge mclk);
      n++;
    end
    repeat (4) @(posedge mclk);
    chk("missing results", 64'h0, 64'(fbq.size() + upq.size()));
    fbq.delete();
    upq.delete();
  endtask : wait_idle
  task automatic swap_case(input logic [1:0] m, input logic [31:0] v);
    wb(1'b1, fbw_pkg::ADR_VIDEO_REG, v);
    wb(1'b1, fbw_pkg::ADR_ROW_BASE, ~v);
    wb(1'b1, fbw_pkg::ADR_STALL_CMD, {30'h0, m});
    if (m == fbw_pkg::SWAP_NOW_VIDEO) begin
      repeat (4) @(posedge mclk);
      ev = v;
    end else begin
      wb(1'b0, fbw_pkg::ADR_STATUS, 32'h0);
      chk("stall pending", 64'h1, 64'(rdq[0]));
      fbq.push_back(mk(1'b1, 24'h0, fill, 32'hFFFF_FFFF));
      fork
        send(1'b0, 1'b0, 1'b0, 5'h0, 24'h0, 32'hFFFF_FFFF, 32'h0);
        begin
          repeat (20) @(posedge mclk);
          chk("held write", 64'h1, 64'(fbq.size()));
          chk("video early", 64'(ev), 64'(video_reg_ff));
          chk("row early", 64'(er), 64'(row_base_ff));
          vblank_pin <= 1'b1;
          repeat (4) @(posedge mclk);
          vblank_pin <= 1'b0;
        end
      join
      wait_idle();
      if (m == fbw_pkg::SWAP_VB_ROW) er = ~v;
      else ev = v;
    end
    chk("video reg", 64'(ev), 64'(video_reg_ff));
    chk("row base", 64'(er), 64'(row_base_ff));
  endtask : swap_case
  // watcher: oldest note against each result
  always @(posedge mclk) begin
    if (resetn && fb_valid_ff && fb_ready) begin
      if (fbq.size() == 0) chk("unexpected fb write", 64'h0, 64'h1);
      else chk_fb(fbq.pop_front(), fb_write_ff);
    end
    if (resetn && up_valid_ff) begin
      if (upq.size() == 0) chk("unexpected upload", 64'h0, 64'h1);
      else chk("upload word", 64'(upq.pop_front()), 64'(up_data_ff));
    end
  end
  // hang guard, well past the run's length
  initial begin
    repeat (20000) @(posedge mclk);
    n_mismatch++;
    stop_test();
  end
  initial begin
    {resetn, cyc, stb, we, span_valid, vblank_pin, slow, adr, dat, span_color, span_req, ev, er} = '0;
    rnd = 32'h9554;
    pix = 24'h000100;
    src = 24'hFFFF38;
    repeat (3) @(posedge mclk);
    resetn <= 1'b1;
    wb(1'b0, fbw_pkg::ADR_STORE_CFG, 32'h0);
    chk("store cfg reset", 64'h8, 64'(rdq));
    wb(1'b0, 8'h40, 32'h0);
    chk("unmapped err", 64'h1, 64'(errq));
    r = nxt();
    win = r[23:0];
    wb(1'b1, fbw_pkg::ADR_WIN_BASE, r);
    wb(1'b0, fbw_pkg::ADR_WIN_BASE, 32'h0);
    chk("window base", 64'({8'h00, win}), 64'(rdq));
    wb(1'b1, fbw_pkg::ADR_PIX_OFS, 32'h0000_0100);
    wb(1'b1, fbw_pkg::ADR_SRC_OFS, 32'h00FF_FF38);
    wb(1'b0, fbw_pkg::ADR_SRC_OFS, 32'h0);
    chk("source offset", 64'h0000_0000_FFFF_FF38, 64'(rdq));
    wb(1'b1, fbw_pkg::ADR_STORE_CFG, 32'h9);
    r = nxt();
    fill = {r, r};
    wb(1'b1, fbw_pkg::ADR_FILL_SINGLE, r);
    wb(1'b0, fbw_pkg::ADR_FILL_HIGH, 32'h0);
    chk("fill high", 64'(r), 64'(rdq));
    fbq.push_back(mk(1'b1, r[23:0], fill, ~r));
    send(1'b0, 1'b0, 1'b1, r[4:0], r[23:0], ~r, 32'h0);
    wait_idle();
    wb(1'b1, fbw_pkg::ADR_SRC_OFS, 32'h0);
    src = 24'h0;
    // 8 bpp fill in halves, memory stalling
    slow <= 1'b1;
    r = nxt();
    fill = {{4{r[15:8]}}, {4{r[7:0]}}};
    wb(1'b1, fbw_pkg::ADR_STORE_CFG, 32'h1);
    wb(1'b1, fbw_pkg::ADR_FILL_LOW, fill[31:0]);
    wb(1'b1, fbw_pkg::ADR_FILL_HIGH, fill[63:32]);
    fbq.push_back(mk(1'b1, 24'h10, fill, r));
    send(1'b0, 1'b0, 1'b0, 5'h1, 24'h10, r, 32'h0);
    wait_idle();
    slow <= 1'b0;
    wb(1'b1, fbw_pkg::ADR_STORE_CFG, 32'h8);
    send(1'b0, 1'b0, 1'b0, 5'h2, 24'h20, 32'hFFFF_FFFF, 32'h0);
    wait_idle();
    for (int i = 0; i < 32; i++) begin
      pat[i] = nxt();
      wb(1'b1, fbw_pkg::ADR_TILE_BASE + 8'(i * 4), pat[i]);
    end
    // constant, 8x8 at 16 and 32 bpp, wrap, pattern off
    for (int c = 0; c < 5; c++) begin
      wb(1'b1, fbw_pkg::ADR_STORE_CFG, {28'h0, tdep[c], 2'b01});
      wb(1'b1, fbw_pkg::ADR_TILE_CFG, {18'h0, tcfg[c]});
      for (int k = 0; k < (8 << tdep[c]); k++)
        fbq.push_back(mk(1'b0, 24'h40 + 24'(k), {32'h0, pat[paddr(tcfg[c], int'(ty[c]), k)]}, 32'h0));
      send(1'b1, 1'b0, 1'b0, ty[c], 24'h40, 32'hFFFF_FFFF, 32'h0);
      wait_idle();
    end
    r = nxt();
    wb(1'b1, fbw_pkg::ADR_STORE_CFG, 32'h1);
    for (int k = 0; k < 8; k++) fbq.push_back(mk(1'b0, 24'(k), {32'h0, r}, 32'h0));
    send(1'b1, 1'b1, 1'b0, 5'h0, 24'h0, 32'hFFFF_FFFF, r);
    wait_idle();
    wb(1'b1, fbw_pkg::ADR_STORE_CFG, 32'h2);
    for (int j = 0; j < 2; j++)
      upq.push_back({pat[4*j+3][7:0], pat[4*j+2][7:0], pat[4*j+1][7:0], pat[4*j][7:0]});
    send(1'b1, 1'b0, 1'b0, 5'h0, 24'h0, 32'hFFFF_FFFF, 32'h0);
    wait_idle();
    wb(1'b1, fbw_pkg::ADR_STORE_CFG, 32'h9);
    swap_case(fbw_pkg::SWAP_NOW_VIDEO, nxt());
    swap_case(fbw_pkg::SWAP_VB_VIDEO, nxt());
    swap_case(fbw_pkg::SWAP_VB_ROW, nxt());
    stop_test();
  end
endmodule : testbench
`default_nettype wire
